// ===== hw/i2b_pkg.sv
// Package: register map, fields, reset values and event codes of the buffer-flag block
// Overview of operation
// - Formatless transmit keeps tx buffer empty flag set
// - Holding-to-shift move sets tx buffer empty flag
// - Receive-to-transmit switch after start sets flag
// - Hidden rx full flag, resets to zero
// - Data read in receive mode clears rx flag
// - Normal receive end moves shift byte, sets flag
// - Eight-bit own address register, resets to zero
// - Slave compares upper seven address bits after start
// - Address register shares offset, reachable while disabled
// - Data write in formatted transmit mode clears tx flag
// - Completed frame moves to empty rx holding buffer
package i2b_pkg;
	// ************************************************
	// Register offsets (byte addresses)
	// ************************************************
	localparam logic [7:0] REG_ADDR = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_ISTS = 8'h0C;
	localparam logic [7:0] REG_IMASK = 8'h10;
	localparam logic [7:0] REG_LINK = 8'h14;
	// ************************************************
	// Fields and reset values
	// ************************************************
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TSEL_BIT = 1;
	localparam int OSA_FMT_BIT = 0;
	localparam int MODE_NOACK_BIT = 0;
	localparam logic [7:0] OSA_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [3:0] IMASK_RST = 4'h0;
	// ************************************************
	// Events, frame and holding buffer layout
	// ************************************************
	localparam int EV_N = 4;
	localparam int EV_TXE = 0;
	localparam int EV_RXF = 1;
	localparam int EV_ADDR = 2;
	localparam int EV_STOP = 3;
	localparam logic [3:0] BITS_LAST = 4'h7;
	localparam logic [3:0] BITS_FRAME = 4'h8;
	localparam int HOLD_N = 2;
	localparam int HOLD_TX = 0;
	localparam int HOLD_RX = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/i2b_hold_mem.sv
// Holding buffers for transmit and receive bytes, registered outputs
`timescale 1ns/1ps
module i2b_hold_mem import i2b_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Write side, one enable per entry
	input wire logic [HOLD_N-1:0] we,
	input wire logic [HOLD_N-1:0][7:0] wdata,
	// Read side
	output logic [HOLD_N-1:0][7:0] q
);
	logic [HOLD_N-1:0][7:0] q_r;
	logic [HOLD_N-1:0][7:0] q_nxt;

	genvar i;
	generate
		for (i = 0; i < HOLD_N; i++) begin : g_ent
			assign q_nxt[i] = we[i] ? wdata[i] : q_r[i];
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule

// ===== hw/i2b_core.sv
// Buffer flags, own slave address and AXI4-Lite registers of the serial interface
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module i2b_core import i2b_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// AXI4-Lite write
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] own_slave_address;
		logic [7:0] mode_register_alias;
		logic interface_enable_bit;
		logic transmit_select;
		logic tsel_d;
		logic tx_buffer_empty_flag;
		logic rx_buffer_full_flag;
		logic sh_full;
		logic [7:0] shift_buffer;
		logic [3:0] bitcnt;
		logic active;
		logic addr_phase;
		logic ack_slot;
		logic ack_me;
		logic sda_drv;
		logic started;
		logic tx_nack;
		logic [EV_N-1:0] ists;
		logic [EV_N-1:0] imask;
	} i2b_state_t;

	i2b_state_t s;
	i2b_state_t n;
	logic [HOLD_N-1:0] mem_we;
	logic [HOLD_N-1:0][7:0] mem_wd;
	logic [HOLD_N-1:0][7:0] mem_q;
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] w1c;
	logic wr_fire;
	logic rd_fire;
	logic frame_done;
	logic addr_hit;
	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic fmtless;
	logic txm;

	// ************************************************
	// Pin edges, seen only after the second flip-flop
	// ************************************************
	assign scl = s.scl_s[1];
	assign sda = s.sda_s[1];
	assign rise = scl & ~s.scl_d;
	assign fall = ~scl & s.scl_d;
	assign start = scl & s.scl_d & s.sda_d & ~sda;
	assign stop = scl & s.scl_d & ~s.sda_d & sda;
	assign fmtless = s.own_slave_address[OSA_FMT_BIT];
	assign txm = s.transmit_select & ~s.addr_phase;

	assign s_axi_awready = ~s.aw_got & ~s.bvalid;
	assign s_axi_wready = ~s.w_got & ~s.bvalid;
	assign s_axi_arready = ~s.rvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	// Open drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe = s.sda_drv;
	assign irq = |(s.ists & s.imask);

	i2b_hold_mem u_mem (
		.core_clk(core_clk),
		.rst(rst),
		.we(mem_we),
		.wdata(mem_wd),
		.q(mem_q)
	);

	always_comb begin
		n = s;
		ev = '0;
		w1c = '0;
		mem_we = '0;
		mem_wd = '0;
		frame_done = 1'b0;
		addr_hit = 1'b0;
		n.scl_s = {s.scl_s[0], scl_i};
		n.sda_s = {s.sda_s[0], sda_i};
		n.scl_d = scl;
		n.sda_d = sda;
		n.tsel_d = s.transmit_select;
		// ************************************************
		// Register writes
		// ************************************************
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		wr_fire = s.aw_got & s.w_got;
		if (wr_fire) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			unique case (s.awaddr)
				REG_ADDR: begin
					// Shared offset: alias register while enabled
					if (s.wstrb[0] && !s.interface_enable_bit) begin
						n.own_slave_address = s.wdata[7:0];
					end else if (s.wstrb[0]) begin
						n.mode_register_alias = s.wdata[7:0];
					end
				end
				REG_CTRL: begin
					if (s.wstrb[0]) begin
						n.interface_enable_bit = s.wdata[CTRL_EN_BIT];
						n.transmit_select = s.wdata[CTRL_TSEL_BIT];
					end
				end
				REG_DATA: begin
					if (s.wstrb[0] && s.interface_enable_bit) begin
						mem_we[HOLD_TX] = 1'b1;
						mem_wd[HOLD_TX] = s.wdata[7:0];
						if (s.transmit_select) begin
							n.tx_buffer_empty_flag = 1'b0;
						end
					end
				end
				REG_ISTS: w1c = s.wstrb[0] ? s.wdata[EV_N-1:0] : '0;
				REG_IMASK: begin
					if (s.wstrb[0]) begin
						n.imask = s.wdata[EV_N-1:0];
					end
				end
				REG_LINK: n.bresp = RESP_OKAY;
				default: n.bresp = RESP_SLVERR;
			endcase
		end
		// ************************************************
		// Register reads
		// ************************************************
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		rd_fire = s_axi_arvalid & s_axi_arready;
		if (rd_fire) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = '0;
			unique case (s_axi_araddr)
				REG_ADDR: n.rdata[7:0] = s.interface_enable_bit ? s.mode_register_alias
					: s.own_slave_address;
				REG_CTRL: begin
					n.rdata[CTRL_EN_BIT] = s.interface_enable_bit;
					n.rdata[CTRL_TSEL_BIT] = s.transmit_select;
				end
				REG_DATA: begin
					if (s.interface_enable_bit) begin
						n.rdata[7:0] = mem_q[HOLD_RX];
						if (!s.transmit_select) begin
							n.rx_buffer_full_flag = 1'b0;
						end
					end
				end
				REG_ISTS: n.rdata[EV_N-1:0] = s.ists;
				REG_IMASK: n.rdata[EV_N-1:0] = s.imask;
				REG_LINK: n.rdata[4:0] = {s.tx_nack, s.ack_slot, s.started,
					s.active & ~s.addr_phase, s.active};
				default: n.rresp = RESP_SLVERR;
			endcase
		end
		// ************************************************
		// Buffer flag clears and receive transfer
		// ************************************************
		if (!s.transmit_select || stop) begin
			n.tx_buffer_empty_flag = 1'b0;
		end
		// Runs after the read clear so a new byte is never lost
		if (s.sh_full && !s.transmit_select && !s.rx_buffer_full_flag) begin
			mem_we[HOLD_RX] = 1'b1;
			mem_wd[HOLD_RX] = s.shift_buffer;
			n.rx_buffer_full_flag = 1'b1;
			n.sh_full = 1'b0;
			ev[EV_RXF] = 1'b1;
		end
		// ************************************************
		// Link engine
		// ************************************************
		if (!s.interface_enable_bit) begin
			n.active = 1'b0;
			n.started = 1'b0;
			n.sda_drv = 1'b0;
		end else if (start && !fmtless) begin
			n.active = 1'b1;
			n.addr_phase = 1'b1;
			n.bitcnt = '0;
			n.ack_slot = 1'b0;
			n.sda_drv = 1'b0;
			n.started = 1'b1;
			n.tx_nack = 1'b0;
		end else if (stop && !fmtless) begin
			n.active = 1'b0;
			n.started = 1'b0;
			n.sda_drv = 1'b0;
			ev[EV_STOP] = 1'b1;
		end else begin
			if (fmtless) begin
				n.active = 1'b1;
				n.addr_phase = 1'b0;
			end
			if (rise && s.active && s.ack_slot) begin
				n.tx_nack = txm & sda;
			end else if (rise && s.active && s.bitcnt <= BITS_LAST) begin
				n.shift_buffer = {s.shift_buffer[6:0], txm ? 1'b0 : sda};
				n.bitcnt = s.bitcnt + 4'h1;
				frame_done = (s.bitcnt == BITS_LAST);
			end
			if (frame_done && s.addr_phase) begin
				n.ack_me = 1'b0;
				if (n.shift_buffer[7:1] == s.own_slave_address[7:1]) begin
					addr_hit = 1'b1;
					n.addr_phase = 1'b0;
					n.transmit_select = n.shift_buffer[0];
					n.ack_me = 1'b1;
					ev[EV_ADDR] = 1'b1;
				end else begin
					n.active = 1'b0;
				end
			end else if (frame_done) begin
				// Receive: byte waits in shift; transmit: shift now empty
				n.sh_full = ~txm;
				n.ack_me = ~txm;
			end
			if (fall && s.active && s.bitcnt == BITS_FRAME) begin
				n.bitcnt = '0;
				n.ack_slot = ~fmtless;
				n.sda_drv = fmtless ? (txm & ~s.shift_buffer[7])
					: (s.ack_me & ~s.mode_register_alias[MODE_NOACK_BIT]);
			end else if (fall && s.active) begin
				n.ack_slot = 1'b0;
				n.sda_drv = txm & ~s.shift_buffer[7] & ~s.tx_nack;
			end
		end
		// ************************************************
		// Transmit flag sets, after every clear
		// ************************************************
		if (s.transmit_select && fmtless) begin
			n.tx_buffer_empty_flag = 1'b1;
		end
		// Not in the switch cycle: the holding byte there may be stale
		if (s.transmit_select && s.tsel_d && !s.tx_buffer_empty_flag && !s.sh_full) begin
			n.shift_buffer = mem_q[HOLD_TX];
			n.sh_full = 1'b1;
			n.tx_buffer_empty_flag = 1'b1;
		end
		if (s.transmit_select && !s.tsel_d && s.started) begin
			n.tx_buffer_empty_flag = 1'b1;
		end
		ev[EV_TXE] = n.tx_buffer_empty_flag & ~s.tx_buffer_empty_flag;
		// Set wins over a same-cycle write-one clear
		n.ists = (s.ists & ~w1c) | ev;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= '0;
			s.own_slave_address <= OSA_RST;
			s.mode_register_alias <= MODE_RST;
			s.imask <= IMASK_RST;
		end else begin
			s <= n;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_fmtless_txe: assert property (s.transmit_select && fmtless |=> s.tx_buffer_empty_flag)
		else $error("formatless transmit left tx empty flag low");
	a_tx_load_move: assert property (s.transmit_select && s.tsel_d && !s.tx_buffer_empty_flag
		&& !s.sh_full |=> s.tx_buffer_empty_flag && s.sh_full
		&& s.shift_buffer == $past(mem_q[HOLD_TX]))
		else $error("holding byte not moved to shift buffer");
	a_tsel_switch: assert property (s.transmit_select && !s.tsel_d && s.started
		|=> s.tx_buffer_empty_flag)
		else $error("switch to transmit did not set tx empty flag");
	a_reset_values: assert property (@(posedge core_clk) disable iff (1'b0)
		rst |=> !s.rx_buffer_full_flag
		&& s.own_slave_address == OSA_RST)
		else $error("reset values wrong");
	a_rx_read_clear: assert property (rd_fire && s_axi_araddr == REG_DATA && s.interface_enable_bit
		&& !s.transmit_select && s.rx_buffer_full_flag |=> !s.rx_buffer_full_flag)
		else $error("data read left rx full flag set");
	a_rx_transfer: assert property (s.sh_full && !s.transmit_select && !s.rx_buffer_full_flag
		|=> s.rx_buffer_full_flag && mem_q[HOLD_RX] == $past(s.shift_buffer))
		else $error("received byte not moved to rx holding buffer");
	a_addr_match: assert property (addr_hit |=> s.active && !s.addr_phase ##1 !s.addr_phase)
		else $error("address match did not select slave");
	a_osa_locked: assert property (s.own_slave_address != $past(s.own_slave_address)
		|-> !$past(s.interface_enable_bit))
		else $error("own address changed while enabled");
	a_tx_write_clear: assert property (wr_fire && s.awaddr == REG_DATA && s.wstrb[0]
		&& s.interface_enable_bit && s.transmit_select && s.tsel_d && !fmtless
		&& (s.tx_buffer_empty_flag || s.sh_full)
		|=> !s.tx_buffer_empty_flag)
		else $error("data write left tx empty flag set");
	a_txe_event: assert property ($rose(s.tx_buffer_empty_flag) |-> s.ists[EV_TXE])
		else $error("tx empty event not recorded");

	c_rx_byte: cover property (s.sh_full && !s.transmit_select ##1 s.rx_buffer_full_flag);
	c_addr_hit: cover property (addr_hit);
	c_tx_load: cover property (s.transmit_select && s.tsel_d && !s.tx_buffer_empty_flag
		&& !s.sh_full);
	c_irq: cover property (irq);
endmodule

// ===== test/i2b_master_model.sv
// Serial bus master model driving the clock and open-drain data line
`timescale 1ns/1ps
module i2b_master_model (
	// Bench clock, only to keep pin changes off its rising edge
	input wire logic core_clk,
	// Pins
	input wire logic sda_in,
	output logic scl,
	output logic sda_m
);
	// Sends whatever address byte the bench passes in; no slave address is built in
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// ****************
	// Bus conditions
	// ****************
	// Clock stands high between frames
	task start();
		@(negedge core_clk);
		sda_m = 1'b0;
		#100 scl = 1'b0;
		#50;
	endtask
	task stop();
		@(negedge core_clk);
		sda_m = 1'b0;
		#50 scl = 1'b1;
		#100 sda_m = 1'b1;
		#100;
	endtask
	// ****************
	// Bit and byte transfers
	// ****************
	// Set data, raise clock, sample the wired line
	task hi(input logic b, output logic s);
		sda_m = b;
		#50 scl = 1'b1;
		#75 s = sda_in;
	endtask
	// Clock may be held high before this, which lets software answer in time
	task lo();
		@(negedge core_clk);
		drop();
	endtask
	// Every delay is whole cycles, so changes stay on falling edges
	task drop();
		#25 scl = 1'b0;
		#50;
	endtask
	// Eight bits MSB first, then the acknowledge slot; left with clock high
	task xfer(input logic [7:0] d, output logic [8:0] q);
		@(negedge core_clk);
		for (int i = 7; i >= 0; i--) begin
			hi(d[i], q[i+1]);
			drop();
		end
		hi(1'b1, q[0]);
	endtask
endmodule

// ===== test/i2b_core_tb.sv
// Self-checking testbench of the buffer-flag and own-address block
`timescale 1ns/1ps
module i2b_core_tb import i2b_pkg::*;;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic scl, sda_m, sda_o, sda_oe, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [8:0] q;
	int n_fail = 0;
	int comparisons = 0;
	// Pull-up on the data line; the device can only pull it low
	wire sda = sda_m & ~(sda_oe & ~sda_o);

	always #12.5 core_clk = ~core_clk;

	i2b_core u_dut (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .scl_i(scl),
		.sda_i(sda), .sda_o, .sda_oe, .irq);
	i2b_master_model u_mst (.core_clk, .sda_in(sda), .scl, .sda_m);

	// ****************
	// Shared tasks
	// ****************
	function automatic logic [31:0] ev(input int b);
		return 32'h1 << b;
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test();
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Address and data offered together, each dropped once taken
	task axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
		if (i == 50) begin
			n_fail++;
			stop_test();
		end
	endtask
	task axr(input logic [7:0] a);
		int i;
		@(posedge core_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		if (i == 50) begin
			n_fail++;
			stop_test();
		end
	endtask

	// ****************
	// Scenarios
	// ****************
	task t_regs();
		axr(REG_ISTS);
		chk("events at reset", rd, 32'h0);
		axr(REG_ADDR);
		chk("own address reset", rd, {24'h0, OSA_RST});
		axw(REG_ADDR, 32'hA4);
		chk("write resp", 32'(resp), 32'(RESP_OKAY));
		axr(REG_ADDR);
		chk("own address", rd, 32'hA4);
		axr(8'h18);
		chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
		axw(8'h18, 32'h0);
		chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
	endtask
	task t_alias();
		axw(REG_CTRL, ev(CTRL_EN_BIT));
		axr(REG_ADDR);
		chk("mode alias", rd, {24'h0, MODE_RST});
		axw(REG_ADDR, 32'h0);
		axw(REG_CTRL, 32'h0);
		axr(REG_ADDR);
		chk("own address kept", rd, 32'hA4);
		axw(REG_CTRL, ev(CTRL_EN_BIT));
	endtask
	task t_rx();
		axw(REG_IMASK, ev(EV_RXF));
		axw(REG_ISTS, 32'hF);
		u_mst.start();
		u_mst.xfer(8'hA4, q);
		chk("address ack", 32'(q[0]), 32'h0);
		u_mst.lo();
		u_mst.xfer(8'h3C, q);
		u_mst.lo();
		axr(REG_ISTS);
		chk("address and rx events", rd, ev(EV_ADDR) | ev(EV_RXF));
		chk("irq raised", 32'(irq), 32'h1);
		axr(REG_DATA);
		chk("rx byte", rd, 32'h3C);
		axw(REG_ISTS, 32'hF);
		chk("irq cleared", 32'(irq), 32'h0);
		u_mst.xfer(8'h5A, q);
		u_mst.lo();
		axr(REG_ISTS);
		chk("rx event after read", rd, ev(EV_RXF));
		axw(REG_ISTS, 32'hF);
		// Holding buffer still full: this byte must stay in the shift buffer
		u_mst.xfer(8'h77, q);
		u_mst.lo();
		axr(REG_ISTS);
		chk("no move while full", rd, 32'h0);
		axr(REG_DATA);
		chk("held byte", rd, 32'h5A);
		u_mst.stop();
	endtask
	task t_nomatch();
		axw(REG_ISTS, 32'hF);
		u_mst.start();
		u_mst.xfer(8'hA6, q);
		chk("foreign address nack", 32'(q[0]), 32'h1);
		u_mst.lo();
		u_mst.stop();
		axr(REG_ISTS);
		chk("no match event", rd & ev(EV_ADDR), 32'h0);
		// Matching address with the acknowledge suppressed through the mode alias
		axw(REG_ADDR, 32'h1);
		u_mst.start();
		u_mst.xfer(8'hA4, q);
		chk("suppressed ack", 32'(q[0]), 32'h1);
		u_mst.lo();
		u_mst.stop();
		axr(REG_ISTS);
		chk("match without ack", rd & ev(EV_ADDR), ev(EV_ADDR));
		axw(REG_ADDR, 32'h0);
	endtask
	task t_tx();
		axw(REG_ISTS, 32'hF);
		u_mst.start();
		u_mst.xfer(8'hA5, q);
		chk("read address ack", 32'(q[0]), 32'h0);
		axr(REG_LINK);
		chk("link status", rd, 32'h0F);
		axr(REG_ISTS);
		chk("tx empty on switch", rd & ev(EV_TXE), ev(EV_TXE));
		axw(REG_ISTS, 32'hF);
		axw(REG_DATA, 32'hC5);
		axr(REG_ISTS);
		chk("tx empty after move", rd & ev(EV_TXE), ev(EV_TXE));
		u_mst.lo();
		u_mst.xfer(8'hFF, q);
		chk("tx byte", 32'(q[8:1]), 32'hC5);
		u_mst.lo();
		u_mst.stop();
	endtask
	task t_fmt();
		axw(REG_CTRL, 32'h0);
		axw(REG_ADDR, ev(OSA_FMT_BIT));
		axw(REG_ISTS, 32'hF);
		axw(REG_CTRL, ev(CTRL_EN_BIT) | ev(CTRL_TSEL_BIT));
		axr(REG_ISTS);
		chk("formatless tx empty", rd & ev(EV_TXE), ev(EV_TXE));
		chk("masked event no irq", 32'(irq), 32'h0);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_alias();
		t_rx();
		t_nomatch();
		t_tx();
		t_fmt();
		stop_test();
	end
	// Hang guard, far above the run length of the whole sequence
	initial begin
		#2000000;
		n_fail++;
		stop_test();
	end
endmodule
